/* hw/pbcc_calendar_clock.sv */
/*
 * Calendar clock: BCD time and calendar counters advanced from a crystal
 * time base, eight byte registers on an asynchronous strobe bus, and an
 * open-drain pulse pin. Assumes all pins are synchronous to CLK and that a
 * pull-up outside gives the pulse pin its high level.
 */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - seconds derived from 32.768 kHz crystal
// - access only when both selects active
// - write strobe rising edge stores data
// - drive data while read strobe low
// - three address bits select eight registers
// - fields held as BCD, tens upper
// - hours bit7: 0 24h, 1 12h
// - bit6 afternoon in 12h, zero in 24h
// - midnight 00H or 92H, noon D2H
// - leap bit7 disables, bit6 enables counter write
// - leap enabled and counter zero: Feb 29
// - control 10 rolls Feb 28 to March
// - modes 0-3 give square waves
// - modes 4-A give interval ticks
// - mode B shows busy; C-F test
// - disable floats pin, flag keeps state
// - crystal flag clears on stop, reset sets
// - busy reads 1 while counters update
// - reads never disturb the counters
// - pulse pin drives low or floats
module pbcc_calendar_clock (
    input  wire  logic       CLK,
    input  wire  logic       SRST,
    input  wire  logic       XTAL,
    input  wire  logic       SEL_N,
    input  wire  logic       SEL,
    input  wire  logic       WR_N,
    input  wire  logic       RD_N,
    input  wire  logic [2:0] ADDR,
    input  wire  logic [7:0] DATA_IN,
    output var   logic [7:0] DATA_OUT,
    output var   logic       DATA_OE,
    output var   logic       PULSE_OUT,
    output var   logic       PULSE_OE
);
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] m, input logic leap);
        case (m)
            8'h02:                      month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default:                    month_len = 8'h31;
        endcase
    endfunction

    // {day carry, next hour}
    function automatic logic [8:0] hour_inc(input logic [7:0] h);
        if (!h[pbcc_pkg::HOUR_FMT_BIT]) begin
            hour_inc = (h == 8'h23) ? {1'b1, 8'h00} : {1'b0, bcd_inc(h)};
        end else if (h[5:0] == 6'h12) begin
            hour_inc = {1'b0, h[7:6], 6'h01};
        end else if (h[5:0] == 6'h11) begin
            hour_inc = {h[6], 1'b1, ~h[6], 6'h12};
        end else begin
            hour_inc = {1'b0, h[7:6], 6'(bcd_inc({2'b00, h[5:0]}))};
        end
    endfunction

    pbcc_pkg::pbcc_bus_t bus_r;
    logic                wr_n_q_r;
    logic                wr_stb;
    logic [7:0]          sec_r, min_r, hour_r, day_r, mon_r, year_r;
    logic [1:0]          leap_ctl_r, leap_cnt_r;
    logic [2:0]          wday_r;
    logic [3:0]          mode_r;
    logic                clk_stop_r, int_stop_r, pulse_dis_r;
    logic                crystal_running_flag_r, busy_r, pulse_flag_r, int_low_r;
    logic                xtal_q_r, xtal_rise;
    logic [pbcc_pkg::PRESC_W-1:0] presc_r;
    logic [12:0]         osc_cnt_r;
    logic                osc_lost;
    logic [pbcc_pkg::INT_W-1:0] int_cnt_r, int_period;
    logic                int_mode, ctl_wr, clk_reset, adjust, int_reset, int_fire;
    logic                sec_tick, c_min, c_hour, c_day, c_mon, c_year, leap_now;
    logic [8:0]          hour_next;
    logic                pulse_lvl;

    // bus pins sampled each cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bus_r    <= '{sel: 1'b0, wr_n: 1'b1, rd_n: 1'b1, addr: 3'h0, data: 8'h00};
            wr_n_q_r <= 1'b1;
        end else begin
            bus_r    <= '{sel: !SEL_N && SEL, wr_n: WR_N, rd_n: RD_N, addr: ADDR,
                          data: DATA_IN};
            wr_n_q_r <= bus_r.wr_n;
        end
    end

    assign wr_stb   = bus_r.sel && bus_r.wr_n && !wr_n_q_r;
    assign ctl_wr   = wr_stb && bus_r.addr == pbcc_pkg::ADDR_CTRL;
    assign int_mode = bus_r.data[7:4] >= pbcc_pkg::MODE_INT_LO
                   && bus_r.data[7:4] <= pbcc_pkg::MODE_INT_HI;
    // control bits mean interval actions in interval modes, clock actions otherwise
    assign clk_reset = ctl_wr && !int_mode && bus_r.data[pbcc_pkg::CTRL_B1];
    assign adjust    = ctl_wr && !int_mode && bus_r.data[pbcc_pkg::CTRL_B2];
    assign int_reset = ctl_wr && int_mode && bus_r.data[pbcc_pkg::CTRL_B1];

    // crystal time base and oscillation watchdog
    assign xtal_rise = XTAL && !xtal_q_r;
    assign osc_lost  = osc_cnt_r == 13'(pbcc_pkg::OSC_TIMEOUT_CYC);
    always_ff @(posedge CLK) begin
        if (SRST) begin
            xtal_q_r  <= 1'b0;
            presc_r   <= '0;
            osc_cnt_r <= '0;
        end else begin
            xtal_q_r <= XTAL;
            if (clk_reset) begin
                presc_r <= '0;
            end else if (xtal_rise && !clk_stop_r) begin
                presc_r <= presc_r + 1'b1;
            end
            if (xtal_rise) begin
                osc_cnt_r <= '0;
            end else if (!osc_lost) begin
                osc_cnt_r <= osc_cnt_r + 13'h0001;
            end
        end
    end

    // flag clears on power-up and on loss; only a clock reset sets it again
    always_ff @(posedge CLK) begin
        if (SRST) begin
            crystal_running_flag_r <= 1'b0;
        end else if (osc_lost) begin
            crystal_running_flag_r <= 1'b0;
        end else if (clk_reset) begin
            crystal_running_flag_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= !clk_stop_r
                   && presc_r >= 15'(pbcc_pkg::XTAL_HZ - pbcc_pkg::BUSY_TICKS);
        end
    end

    // counter carry chain
    assign sec_tick  = xtal_rise && !clk_stop_r && !clk_reset && (&presc_r);
    assign c_min     = (sec_tick && sec_r == 8'h59) || (adjust && sec_r >= 8'h30);
    assign c_hour    = c_min && min_r == 8'h59;
    assign hour_next = hour_inc(hour_r);
    assign c_day     = c_hour && hour_next[8];
    assign leap_now  = !leap_ctl_r[1] && leap_cnt_r == 2'b00;
    assign c_mon     = c_day && day_r == month_len(mon_r, leap_now);
    assign c_year    = c_mon && mon_r == 8'h12;

    // a host write to a field wins over the count in the same cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sec_r <= pbcc_pkg::RST_SEC;
            min_r <= pbcc_pkg::RST_SEC;
        end else begin
            if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_SEC) begin
                sec_r <= bus_r.data;
            end else if (adjust || (sec_tick && sec_r == 8'h59)) begin
                sec_r <= 8'h00;
            end else if (sec_tick) begin
                sec_r <= bcd_inc(sec_r);
            end
            if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_MIN) begin
                min_r <= bus_r.data;
            end else if (c_hour) begin
                min_r <= 8'h00;
            end else if (c_min) begin
                min_r <= bcd_inc(min_r);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            hour_r <= pbcc_pkg::RST_HOUR;
        end else if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_HOUR) begin
            hour_r <= {bus_r.data[7], bus_r.data[7] & bus_r.data[6], bus_r.data[5:0]};
        end else if (c_hour) begin
            hour_r <= hour_next[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            leap_ctl_r <= 2'b00;
            leap_cnt_r <= 2'b00;
            wday_r     <= 3'h0;
        end else if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_LEAP) begin
            leap_ctl_r <= bus_r.data[7:6];
            if (bus_r.data[pbcc_pkg::LEAP_WEN_BIT]) begin
                leap_cnt_r <= bus_r.data[5:4];
            end
            wday_r <= bus_r.data[2:0];
        end else begin
            if (c_year) begin
                leap_cnt_r <= leap_cnt_r + 2'b01;
            end
            if (c_day) begin
                wday_r <= (wday_r == 3'h6) ? 3'h0 : wday_r + 3'h1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            day_r  <= pbcc_pkg::RST_DAY;
            mon_r  <= pbcc_pkg::RST_MON;
            year_r <= pbcc_pkg::RST_SEC;
        end else begin
            if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_DAY) begin
                day_r <= bus_r.data;
            end else if (c_mon) begin
                day_r <= 8'h01;
            end else if (c_day) begin
                day_r <= bcd_inc(day_r);
            end
            if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_MON) begin
                mon_r <= bus_r.data;
            end else if (c_year) begin
                mon_r <= 8'h01;
            end else if (c_mon) begin
                mon_r <= bcd_inc(mon_r);
            end
            if (wr_stb && bus_r.addr == pbcc_pkg::ADDR_YEAR) begin
                year_r <= bus_r.data;
            end else if (c_year) begin
                year_r <= (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
            end
        end
    end

    // mode and control state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_r      <= pbcc_pkg::RST_MODE;
            clk_stop_r  <= 1'b0;
            int_stop_r  <= 1'b0;
            pulse_dis_r <= 1'b0;
        end else if (ctl_wr) begin
            mode_r <= bus_r.data[7:4];
            if (int_mode) begin
                int_stop_r  <= bus_r.data[pbcc_pkg::CTRL_B0];
                pulse_dis_r <= bus_r.data[pbcc_pkg::CTRL_B2];
            end else begin
                clk_stop_r <= bus_r.data[pbcc_pkg::CTRL_B0];
            end
        end
    end

    // interval ticks counted in crystal periods
    always_comb begin
        case (mode_r)
            4'h4:    int_period = pbcc_pkg::INT_P0;
            4'h5:    int_period = pbcc_pkg::INT_P1;
            4'h6:    int_period = pbcc_pkg::INT_P2;
            4'h7:    int_period = pbcc_pkg::INT_P3;
            4'h8:    int_period = pbcc_pkg::INT_P4;
            4'h9:    int_period = pbcc_pkg::INT_P5;
            default: int_period = pbcc_pkg::INT_P6;
        endcase
    end

    assign int_fire = xtal_rise && !int_stop_r && int_cnt_r >= int_period - 1'b1;
    always_ff @(posedge CLK) begin
        if (SRST || int_reset) begin
            int_cnt_r <= '0;
            int_low_r <= 1'b0;
        end else if (xtal_rise && !int_stop_r) begin
            int_cnt_r <= int_fire ? '0 : int_cnt_r + 1'b1;
            int_low_r <= int_fire; // held low for one crystal period
        end
    end

    always_comb begin
        if (mode_r <= pbcc_pkg::MODE_SQ64) begin
            // square taps on prescaler bits 3, 4, 6 and 8
            pulse_lvl = mode_r[1] ? presc_r[4'h6 + {2'b00, mode_r[0], 1'b0}]
                                  : presc_r[4'h3 + {3'b000, mode_r[0]}];
        end else if (mode_r <= pbcc_pkg::MODE_INT_HI) begin
            pulse_lvl = int_low_r;
        end else if (mode_r == pbcc_pkg::MODE_BUSY) begin
            pulse_lvl = busy_r;
        end else begin
            pulse_lvl = 1'b0; // test codes leave the pin idle
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pulse_flag_r <= 1'b0;
            PULSE_OE     <= 1'b0;
            PULSE_OUT    <= 1'b0;
        end else begin
            PULSE_OUT    <= 1'b0;
            pulse_flag_r <= pulse_lvl;
            PULSE_OE     <= pulse_lvl && !pulse_dis_r;
        end
    end

    // reads only select data; nothing below feeds back into the counters
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
        end else begin
            DATA_OE <= bus_r.sel && !bus_r.rd_n;
            case (bus_r.addr)
                pbcc_pkg::ADDR_SEC:  DATA_OUT <= sec_r;
                pbcc_pkg::ADDR_MIN:  DATA_OUT <= min_r;
                pbcc_pkg::ADDR_HOUR: DATA_OUT <= hour_r;
                pbcc_pkg::ADDR_LEAP: DATA_OUT <= {leap_ctl_r, leap_cnt_r, 1'b0, wday_r};
                pbcc_pkg::ADDR_DAY:  DATA_OUT <= day_r;
                pbcc_pkg::ADDR_MON:  DATA_OUT <= mon_r;
                pbcc_pkg::ADDR_YEAR: DATA_OUT <= year_r;
                default:             DATA_OUT <= {mode_r, 1'b0, pulse_flag_r, crystal_running_flag_r, busy_r};
            endcase
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_write(logic [2:0] a);
        wr_stb && bus_r.addr == a;
    endsequence

    a_read_select:  assert property (DATA_OE |-> $past(!SEL_N && SEL && !RD_N, 2))
        else $error("data driven without select and read");
    a_write_sec:    assert property (s_write(pbcc_pkg::ADDR_SEC) |=> sec_r == $past(bus_r.data))
        else $error("seconds write not stored");
    a_sec_wrap:     assert property (sec_tick && sec_r == 8'h59 && !wr_stb |=> sec_r == 8'h00
                                     ##0 min_r != $past(min_r) || $past(min_r) == 8'h59)
        else $error("seconds rollover wrong");
    a_pm_midnight:  assert property (c_hour && hour_r == 8'hD1 && !wr_stb |=> hour_r == 8'h92)
        else $error("12h midnight wrong");
    a_hour_24_pm:   assert property (!hour_r[7] |-> !hour_r[6])
        else $error("afternoon bit set in 24h");
    a_leap_feb:     assert property (c_day && mon_r == 8'h02 && day_r == 8'h28 && leap_now
                                     && !(wr_stb && bus_r.addr == pbcc_pkg::ADDR_DAY)
                                     |=> day_r == 8'h29)
        else $error("leap February short");
    a_pin_float:    assert property (pulse_dis_r [*2] |-> !PULSE_OE)
        else $error("pulse pin driven while disabled");
    a_osc_lost:     assert property (osc_lost |=> !crystal_running_flag_r ##1 !crystal_running_flag_r || clk_reset)
        else $error("crystal flag not cleared");
endmodule // pbcc_calendar_clock
`default_nettype wire

/* include/pbcc_pkg.sv */
/*
 * Shared constants and types for the parallel-bus calendar clock:
 * register offsets, field positions, reset values, pulse modes and timing.
 * Assumes a 40 MHz system clock and a 32.768 kHz crystal level on a pin.
 */
`default_nettype none
package pbcc_pkg;
    // register offsets
    localparam logic [2:0] ADDR_SEC   = 3'h0;
    localparam logic [2:0] ADDR_MIN   = 3'h1;
    localparam logic [2:0] ADDR_HOUR  = 3'h2;
    localparam logic [2:0] ADDR_LEAP  = 3'h3;
    localparam logic [2:0] ADDR_DAY   = 3'h4;
    localparam logic [2:0] ADDR_MON   = 3'h5;
    localparam logic [2:0] ADDR_YEAR  = 3'h6;
    localparam logic [2:0] ADDR_CTRL  = 3'h7;
    // field positions
    localparam int HOUR_FMT_BIT   = 7;
    localparam int HOUR_PM_BIT    = 6;
    localparam int LEAP_DIS_BIT   = 7;
    localparam int LEAP_WEN_BIT   = 6;
    localparam int CTRL_B0        = 0;
    localparam int CTRL_B1        = 1;
    localparam int CTRL_B2        = 2;
    // reset values
    localparam logic [7:0] RST_SEC   = 8'h00;
    localparam logic [7:0] RST_HOUR  = 8'h00;
    localparam logic [7:0] RST_DAY   = 8'h01;
    localparam logic [7:0] RST_MON   = 8'h01;
    localparam logic [3:0] RST_MODE  = 4'h0;
    // pulse output modes
    localparam logic [3:0] MODE_SQ64    = 4'h3;
    localparam logic [3:0] MODE_INT_LO  = 4'h4;
    localparam logic [3:0] MODE_INT_HI  = 4'hA;
    localparam logic [3:0] MODE_BUSY    = 4'hB;
    // timing
    localparam int CLK_HZ          = 40_000_000;
    localparam int XTAL_HZ         = 32_768;
    localparam int PRESC_W         = 15;
    localparam int BUSY_TICKS      = 2;
    localparam int OSC_TIMEOUT_NS  = 100_000;
    localparam int OSC_TIMEOUT_CYC = (OSC_TIMEOUT_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int INT_W           = 21;
    localparam logic [INT_W-1:0] INT_P0 = 21'd16;
    localparam logic [INT_W-1:0] INT_P1 = 21'd32;
    localparam logic [INT_W-1:0] INT_P2 = 21'd128;
    localparam logic [INT_W-1:0] INT_P3 = 21'd512;
    localparam logic [INT_W-1:0] INT_P4 = 21'd32768;
    localparam logic [INT_W-1:0] INT_P5 = 21'd327680;
    localparam logic [INT_W-1:0] INT_P6 = 21'd1966080;

    typedef struct packed {
        logic       sel;
        logic       wr_n;
        logic       rd_n;
        logic [2:0] addr;
        logic [7:0] data;
    } pbcc_bus_t;
endpackage
`default_nettype wire

/* tb/pbcc_host_model.sv */
/*
 * Host processor model for the calendar clock: strobe-bus writes and reads.
 * Assumes a free-running CLK; drives its pins just after falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
module pbcc_host_model (
    input  wire logic                clk,
    input  wire logic [7:0]          data_out,
    input  wire logic                data_oe,
    output var  logic                sel_n,
    output var  pbcc_pkg::pbcc_bus_t bus,
    output wire logic [7:0]          wire_data
);
    logic drive_r;

    // released bus shows the inverse of the last byte, not a stale copy
    assign wire_data = data_oe ? data_out : (drive_r ? bus.data : ~bus.data);

    initial begin
        sel_n   = 1'b1;
        bus     = '{sel: 1'b0, wr_n: 1'b1, rd_n: 1'b1, addr: 3'h0, data: 8'h00};
        drive_r = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic en);
        @(negedge clk);
        sel_n    = ~en;
        bus.sel  = en;
        bus.addr = a;
        bus.data = d;
        drive_r  = 1'b1;
        bus.wr_n = 1'b0;
        repeat (2) @(negedge clk);
        bus.wr_n = 1'b1;
        // address and data held past the strobe edge
        repeat (3) @(negedge clk);
        sel_n   = 1'b1;
        bus.sel = 1'b0;
        drive_r = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic open_rd(input logic [2:0] a);
        @(negedge clk);
        sel_n    = 1'b0;
        bus.sel  = 1'b1;
        bus.addr = a;
        bus.rd_n = 1'b0;
    endtask

    task automatic close_rd;
        bus.rd_n = 1'b1;
        sel_n    = 1'b1;
        bus.sel  = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
        open_rd(a);
        repeat (3) @(negedge clk);
        d  = wire_data;
        oe = data_oe;
        close_rd;
    endtask
endmodule // pbcc_host_model
`default_nettype wire

/* tb/pbcc_calendar_clock_bench.sv */
/*
 * Self-checking bench for the calendar clock: registers, pulse modes, rollover.
 * Assumes the crystal pin may run fast: it toggles every CLK so a second is short.
 */
`timescale 1ns/10ps
`default_nettype none
module pbcc_calendar_clock_bench;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    logic                xtal = 1'b0;
    logic                xtal_run = 1'b1;
    logic                sel_n;
    pbcc_pkg::pbcc_bus_t bus;
    logic [7:0]          data_in;
    logic [7:0]          data_out;
    logic                data_oe;
    logic                pulse_out;
    logic                pulse_oe;
    int                  failures = 0;
    int                  n_tests = 0;
    int                  cycles = 0;

    pbcc_calendar_clock pbcc_calendar_clock_inst (
        .CLK(clk), .SRST(srst), .XTAL(xtal), .SEL_N(sel_n), .SEL(bus.sel),
        .WR_N(bus.wr_n), .RD_N(bus.rd_n), .ADDR(bus.addr), .DATA_IN(data_in),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .PULSE_OUT(pulse_out), .PULSE_OE(pulse_oe)
    );
    pbcc_host_model pbcc_host_model_inst (
        .clk(clk), .data_out(data_out), .data_oe(data_oe), .sel_n(sel_n), .bus(bus),
        .wire_data(data_in)
    );

    always #12.5 clk = ~clk;
    // crystal sped up to one rise per two CLK cycles to keep the run short
    always @(negedge clk) if (xtal_run) xtal <= ~xtal;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures++;
            stop_test;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        logic       oe;
        pbcc_host_model_inst.rd(a, d, oe);
        chk({23'h0, oe, d & m}, {24'h1, e});
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        pbcc_host_model_inst.wr(a, d, 1'b1);
    endtask

    task automatic meas(output int hi, output int per);
        int n;
        n = 0;
        hi = 0;
        while (pulse_oe === 1'b1 && n < 3000) begin @(negedge clk); n++; end
        while (pulse_oe !== 1'b1 && n < 6000) begin @(negedge clk); n++; end
        while (pulse_oe === 1'b1 && hi < 3000) begin @(negedge clk); hi++; end
        per = hi;
        while (pulse_oe !== 1'b1 && per < 3000) begin @(negedge clk); per++; end
    endtask

    task automatic quiet(input int n, output int po, output int fl);
        po = 0;
        fl = 0;
        pbcc_host_model_inst.open_rd(pbcc_pkg::ADDR_CTRL);
        repeat (n) begin
            @(negedge clk);
            po += (pulse_oe === 1'b1);
            fl += (data_out[2] === 1'b1);
        end
        pbcc_host_model_inst.close_rd;
    endtask

    task automatic t_reset;
        rdc(pbcc_pkg::ADDR_CTRL, 8'hF2, 8'h00);
        rdc(pbcc_pkg::ADDR_HOUR, 8'hFF, pbcc_pkg::RST_HOUR);
    endtask

    task automatic t_regs;
        logic [2:0] a[5] = '{pbcc_pkg::ADDR_SEC, pbcc_pkg::ADDR_MIN, pbcc_pkg::ADDR_DAY,
                             pbcc_pkg::ADDR_MON, pbcc_pkg::ADDR_YEAR};
        logic [7:0] v[5] = '{8'h37, 8'h42, 8'h19, 8'h12, 8'h99};
        pbcc_host_model_inst.wr(pbcc_pkg::ADDR_SEC, 8'h45, 1'b0);
        rdc(pbcc_pkg::ADDR_SEC, 8'hFF, pbcc_pkg::RST_SEC);
        for (int i = 0; i < 5; i++) wr(a[i], v[i]);
        for (int i = 0; i < 5; i++) rdc(a[i], 8'hFF, v[i]);
        chk({31'h0, data_oe}, 32'h0);
        wr(pbcc_pkg::ADDR_HOUR, 8'h52);
        rdc(pbcc_pkg::ADDR_HOUR, 8'hFF, 8'h12);
        wr(pbcc_pkg::ADDR_LEAP, 8'h35);
        rdc(pbcc_pkg::ADDR_LEAP, 8'hFF, 8'h05);
        wr(pbcc_pkg::ADDR_LEAP, 8'h75);
        rdc(pbcc_pkg::ADDR_LEAP, 8'hFF, 8'h75);
    endtask

    task automatic t_square;
        int w[4] = '{16, 32, 128, 512};
        int hi;
        int per;
        for (int m = 0; m < 4; m++) begin
            wr(pbcc_pkg::ADDR_CTRL, {m[3:0], 4'h0});
            meas(hi, per);
            chk(hi, w[m]);
            chk(per, 2 * w[m]);
            chk({31'h0, pulse_out}, 32'h0);
        end
    endtask

    task automatic t_interval;
        int p[4] = '{32, 64, 256, 1024};
        int hi;
        int per;
        for (int m = 4; m < 8; m++) begin
            wr(pbcc_pkg::ADDR_CTRL, {m[3:0], 4'h2});
            meas(hi, per);
            chk(hi, 2);
            chk(per, p[m - 4]);
        end
        wr(pbcc_pkg::ADDR_CTRL, 8'h41);
        quiet(80, hi, per);
        chk(hi, 0);
        wr(pbcc_pkg::ADDR_CTRL, 8'h44);
        quiet(80, hi, per);
        chk(hi, 0);
        chk(per > 0, 1);
        // disable is sticky outside interval modes: turn the pin back on here
        wr(pbcc_pkg::ADDR_CTRL, 8'h40);
        meas(hi, per);
        chk(per, 32);
    endtask

    task automatic t_second;
        logic [2:0] a[6] = '{pbcc_pkg::ADDR_SEC, pbcc_pkg::ADDR_MIN, pbcc_pkg::ADDR_HOUR,
                             pbcc_pkg::ADDR_LEAP, pbcc_pkg::ADDR_DAY, pbcc_pkg::ADDR_MON};
        logic [7:0] v[6] = '{8'h59, 8'h59, 8'hD1, 8'h86, 8'h28, 8'h02};
        logic [7:0] e[6] = '{8'h00, 8'h00, 8'h92, 8'hB0, 8'h01, 8'h03};
        int n;
        int hi;
        for (int i = 0; i < 6; i++) wr(a[i], v[i]);
        wr(pbcc_pkg::ADDR_CTRL, 8'hB2);
        rdc(pbcc_pkg::ADDR_CTRL, 8'hF2, 8'hB2);
        // seconds held under read through the busy window
        pbcc_host_model_inst.open_rd(pbcc_pkg::ADDR_SEC);
        n = 0;
        hi = 0;
        while (pulse_oe !== 1'b1 && n < 70000) begin @(negedge clk); n++; end
        while (pulse_oe === 1'b1 && hi < 100) begin @(negedge clk); hi++; end
        pbcc_host_model_inst.close_rd;
        chk(hi, 4);
        for (int i = 0; i < 6; i++) rdc(a[i], 8'hFF, e[i]);
    endtask

    task automatic t_leap;
        logic [2:0] a[6] = '{pbcc_pkg::ADDR_SEC, pbcc_pkg::ADDR_MIN, pbcc_pkg::ADDR_HOUR,
                             pbcc_pkg::ADDR_LEAP, pbcc_pkg::ADDR_DAY, pbcc_pkg::ADDR_MON};
        logic [7:0] v[6] = '{8'h45, 8'h59, 8'h23, 8'h40, 8'h28, 8'h02};
        logic [7:0] e[6] = '{8'h00, 8'h00, 8'h00, 8'h41, 8'h29, 8'h02};
        for (int i = 0; i < 6; i++) wr(a[i], v[i]);
        // adjust with seconds past 30 carries to the day without waiting a second
        wr(pbcc_pkg::ADDR_CTRL, 8'h04);
        for (int i = 0; i < 6; i++) rdc(a[i], 8'hFF, e[i]);
    endtask

    task automatic t_osc;
        xtal_run = 1'b0;
        repeat (4100) @(negedge clk);
        rdc(pbcc_pkg::ADDR_CTRL, 8'h02, 8'h00);
        xtal_run = 1'b1;
        repeat (20) @(negedge clk);
        rdc(pbcc_pkg::ADDR_CTRL, 8'h02, 8'h00);
        wr(pbcc_pkg::ADDR_CTRL, 8'h02);
        rdc(pbcc_pkg::ADDR_CTRL, 8'h02, 8'h02);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_reset;
        t_regs;
        t_square;
        t_interval;
        t_second;
        t_leap;
        t_osc;
        stop_test;
    end
endmodule // pbcc_calendar_clock_bench
`default_nettype wire
